//--- src/pin_pwm_square_wave_output_wake_block.sv
// general pins with pwm, square wave output and wake detection
`timescale 1ns/1ps
`include "ppfwb_map.svh"

module pin_pwm_square_wave_output_wake_block #(
    parameter int unsigned NUM_PINS = `PPFWB_NUM_PINS,
    parameter int unsigned NUM_PWM  = `PPFWB_NUM_PWM,
    parameter int unsigned TICK_DIV = `PPFWB_TICK_DIV
) (
    input  logic                                   clk,
    input  logic                                   resetn,
    input  ppfwb_pkg::ppfwb_pin_cfg_s              pin_cfg,
    input  ppfwb_pkg::ppfwb_pwm_cfg_s              pwm_cfg,
    input  ppfwb_pkg::ppfwb_wake_e [`PPFWB_NUM_WAKE-1:0] wake_mode,
    input  ppfwb_pkg::ppfwb_pins_t                 pin_in,
    input  ppfwb_pkg::ppfwb_wk_t                   wake_pin,
    output ppfwb_pkg::ppfwb_pins_t                 pin_out,
    output ppfwb_pkg::ppfwb_pins_t                 pin_oe,
    output ppfwb_pkg::ppfwb_pins_t                 pin_pullup,
    output ppfwb_pkg::ppfwb_pins_t                 pin_value,
    output ppfwb_pkg::ppfwb_wk_t                   wake_event,
    output logic                                   wake_any
);
    import ppfwb_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // state fields are sized by the map header, so the counts are fixed
    if (NUM_PINS != `PPFWB_NUM_PINS)
    begin : g_pins_chk
        $error("pin count must match the map header");
    end
    if (NUM_PWM != `PPFWB_NUM_PWM)
    begin : g_pwm_chk
        $error("pwm channel count must match the map header");
    end
    if (TICK_DIV < 1 || TICK_DIV > (1 << `PPFWB_DIV_W))
    begin : g_div_chk
        $error("tick divider out of range");
    end

    localparam ppfwb_cnt_t MIN_PER    = ppfwb_cnt_t'(`PPFWB_PWM_MIN_PER);
    localparam ppfwb_cnt_t SQ_MAX_INC = ppfwb_cnt_t'(`PPFWB_SQ_MAX_INC);
    localparam logic [`PPFWB_DIV_W-1:0] DIV_LAST = `PPFWB_DIV_W'(TICK_DIV - 1);

    ppfwb_state_s st_r;
    ppfwb_state_s st_nxt;
    ppfwb_cnt_t   eff_per;
    ppfwb_cnt_t   eff_inc;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic pwm_active(input ppfwb_cnt_t cnt, input ppfwb_cnt_t duty);
        pwm_active = cnt < duty;
    endfunction

    // a bit moves only once the second and third stages agree
    function automatic ppfwb_pins_t settle(
        input ppfwb_pins_t a,
        input ppfwb_pins_t b,
        input ppfwb_pins_t held
    );
        settle = (b & ~(a ^ b)) | (held & (a ^ b));
    endfunction

    // periods shorter than the fastest allowed rate are stretched to it
    assign eff_per = (pwm_cfg.period < MIN_PER) ? MIN_PER : pwm_cfg.period;
    assign eff_inc = (pwm_cfg.sq_inc > SQ_MAX_INC) ? SQ_MAX_INC : pwm_cfg.sq_inc;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        // 4 MHz tick from the 20 MHz clock
        if (st_r.div == DIV_LAST)
        begin
            st_nxt.div  = '0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.div = st_r.div + `PPFWB_DIV_W'(1);
        end

        // one shared period counter serves both channels
        if (st_r.cnt >= eff_per)
        begin
            st_nxt.cnt = '0;
        end
        else if (st_r.tick)
        begin
            if (st_r.cnt == eff_per - ppfwb_cnt_t'(1))
            begin
                st_nxt.cnt = '0;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt + ppfwb_cnt_t'(1);
            end
        end

        // compare against the next count so the output is a clean flop
        for (int i = 0; i < NUM_PWM; i++)
        begin
            st_nxt.pwm[i] = pwm_active(st_nxt.cnt, pwm_cfg.duty[i]);
        end

        // phase accumulator; zero increment freezes the output
        st_nxt.acc = st_r.acc + eff_inc;
        st_nxt.sq  = st_r.acc[`PPFWB_SQ_MSB];

        // input synchronisers
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.pv = settle(st_r.s2, st_r.s3, st_r.pv);
        st_nxt.w1 = wake_pin;
        st_nxt.w2 = st_r.w1;
        st_nxt.w3 = st_r.w2;
        st_nxt.wv = ppfwb_wk_t'(settle(ppfwb_pins_t'(st_r.w2),
                                       ppfwb_pins_t'(st_r.w3),
                                       ppfwb_pins_t'(st_r.wv)));
        st_nxt.wp = st_r.wv;

        // pin drive per function select
        for (int p = 0; p < NUM_PINS; p++)
        begin
            unique case (pin_cfg.pin_function_select[p])
                PPFWB_FN_GPIO:
                begin
                    st_nxt.po[p] = pin_cfg.level[p];
                    st_nxt.oe[p] = pin_cfg.dir[p];
                end
                PPFWB_FN_PWM0:
                begin
                    st_nxt.po[p] = st_r.pwm[0];
                    st_nxt.oe[p] = 1'b1;
                end
                PPFWB_FN_PWM1:
                begin
                    st_nxt.po[p] = st_r.pwm[1];
                    st_nxt.oe[p] = 1'b1;
                end
                PPFWB_FN_SQ:
                begin
                    st_nxt.po[p] = st_r.sq;
                    st_nxt.oe[p] = 1'b1;
                end
            endcase
        end

        // wake detection on settled levels
        for (int w = 0; w < `PPFWB_NUM_WAKE; w++)
        begin
            unique case (wake_mode[w])
                PPFWB_WAKE_OFF:    st_nxt.wake[w] = 1'b0;
                PPFWB_WAKE_LOW:    st_nxt.wake[w] = ~st_r.wv[w];
                PPFWB_WAKE_HIGH:   st_nxt.wake[w] = st_r.wv[w];
                PPFWB_WAKE_CHANGE: st_nxt.wake[w] = st_r.wv[w] ^ st_r.wp[w];
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pin_out    = st_r.po;
    assign pin_oe     = st_r.oe;
    // pull-up only ever acts on a pin that is not driven
    assign pin_pullup = pin_cfg.pull & ~st_r.oe;
    assign pin_value  = st_r.pv;
    assign wake_event = st_r.wake;
    assign wake_any   = |st_r.wake;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic full0;
    logic zero0;
    logic same_duty;
    logic sq_zero;
    assign full0     = pwm_cfg.duty[0] >= eff_per;
    assign zero0     = pwm_cfg.duty[0] == '0;
    assign same_duty = pwm_cfg.duty[0] == pwm_cfg.duty[1];
    assign sq_zero   = pwm_cfg.sq_inc == '0;

    sequence pin_steady_s;
        $stable(pin_in) [*4];
    endsequence

    sequence wake_steady_s;
        $stable(wake_pin) [*4];
    endsequence

    sequence tick_gap_s;
        !st_r.tick [*4] ##1 st_r.tick;
    endsequence

    pin_settle_a: assert property (pin_steady_s |-> pin_value == pin_in)
        else $error("pin value did not follow a steady input");

    dir_oe_a: assert property (
        pin_cfg.pin_function_select[1] == PPFWB_FN_GPIO |=> pin_oe[1] == $past(pin_cfg.dir[1])
    )
        else $error("gpio enable does not follow direction");

    gpio_level_a: assert property (
        pin_cfg.pin_function_select[1] == PPFWB_FN_GPIO
        |=> pin_out[1] == $past(pin_cfg.level[1])
    )
        else $error("gpio level not driven to the pin");

    pull_follow_a: assert property (
        $past(pin_cfg.dir) == '0 && $past(pin_cfg.pin_function_select) == '0
        |-> pin_pullup == pin_cfg.pull
    )
        else $error("pull-up does not follow the setting on an input pin");

    alt_sq_a: assert property (
        pin_cfg.pin_function_select[6] == PPFWB_FN_SQ
        |=> pin_out[6] == $past(st_r.sq) && pin_oe[6]
    )
        else $error("square wave not routed to selected pin");

    first_pwm_a: assert property (
        pin_cfg.pin_function_select[4] == PPFWB_FN_PWM0
        |=> pin_out[4] == $past(st_r.pwm[0]) && pin_oe[4]
    )
        else $error("first pwm channel not routed to selected pin");

    second_pwm_a: assert property (
        pin_cfg.pin_function_select[5] == PPFWB_FN_PWM1
        |=> pin_out[5] == $past(st_r.pwm[1]) && pin_oe[5]
    )
        else $error("second pwm channel not routed to selected pin");

    tick_rate_a: assert property (st_r.tick |=> tick_gap_s)
        else $error("tick spacing is not five clocks");

    // a period change may leave the count above the new end for one cycle
    min_per_a: assert property (
        $stable(eff_per) |-> eff_per >= MIN_PER && st_r.cnt < eff_per
    )
        else $error("pwm period below the fastest rate");

    duty_full_a: assert property ($past(full0) |-> st_r.pwm[0])
        else $error("full duty output went inactive");

    duty_zero_a: assert property ($past(zero0) |-> !st_r.pwm[0])
        else $error("zero duty output went active");

    shared_per_a: assert property ($past(same_duty) |-> st_r.pwm[0] == st_r.pwm[1])
        else $error("channels with equal duty differ");

    sq_hold_a: assert property ($past(sq_zero) && sq_zero |=> $stable(st_r.sq))
        else $error("square wave moved at zero increment");

    cnt_step_a: assert property (
        st_r.tick && st_r.cnt < eff_per - ppfwb_cnt_t'(1) && $stable(eff_per)
        |=> st_r.cnt == $past(st_r.cnt) + ppfwb_cnt_t'(1) || $changed(eff_per)
    )
        else $error("period counter did not step on tick");

    cnt_wrap_a: assert property (
        st_r.tick && st_r.cnt == eff_per - ppfwb_cnt_t'(1) |=> st_r.cnt == '0
    )
        else $error("period counter did not wrap at the period end");

    wake_low_a: assert property (
        wake_mode[0] == PPFWB_WAKE_LOW && !st_r.wv[0] |=> wake_event[0]
    )
        else $error("low level wake missed");

    wake_chg_a: assert property (
        wake_mode[1] == PPFWB_WAKE_CHANGE && $changed(st_r.wv[1]) |=> wake_event[1]
    )
        else $error("change wake missed");

    wake_high_a: assert property (
        wake_mode[2] == PPFWB_WAKE_HIGH && st_r.wv[2] |=> wake_event[2]
    )
        else $error("high level wake missed");

    wake_off_a: assert property (wake_mode[0] == PPFWB_WAKE_OFF |=> !wake_event[0])
        else $error("wake raised while disabled");

    // the synchroniser refills from zero after reset, so skip windows begun in reset
    wake_sync_a: assert property (
        wake_steady_s ##0 $past(resetn, 4) |-> st_r.wv == wake_pin
    )
        else $error("wake level did not follow a steady pin");

endmodule

//--- src/ppfwb_map.svh
// constants for the pin, pwm, square wave and wake block
`ifndef PPFWB_MAP_SVH
`define PPFWB_MAP_SVH
// Contract
// - eighteen general pins exist, each configured and read on its own.
// - each general pin has its own direction bit choosing input or output.
// - an input pin has a selectable internal pull-up or none.
// - pwm and square wave are alternate pin functions chosen per pin by pin_function_select.
// - pwm comes from 32-bit timers counting a 4 MHz tick.
// - the pwm frequency is programmable with 1 MHz as its highest value.
// - the pwm duty spans from always inactive to always active.
// - both pwm pins share one frequency and keep their own duty.
// - the square wave output has equal high and low time, from 0 Hz up to 4 MHz; the accumulator top bit used gives halves of 2 and 3 clocks at 4 MHz.
// - each wake pin triggers on a low level, a high level or any change.
// - wake is offered on the clear-to-send, receive-data and shared_wake_input pins.

`define PPFWB_NUM_PINS    18
`define PPFWB_NUM_PWM     2
`define PPFWB_NUM_WAKE    3
`define PPFWB_TIMER_W     32
`define PPFWB_DIV_W       3
`define PPFWB_CLK_HZ      20000000
`define PPFWB_TICK_HZ     4000000
`define PPFWB_TICK_DIV    (`PPFWB_CLK_HZ / `PPFWB_TICK_HZ)
`define PPFWB_PWM_MAX_HZ  1000000
`define PPFWB_PWM_MIN_PER (`PPFWB_TICK_HZ / `PPFWB_PWM_MAX_HZ)
`define PPFWB_SQ_MAX_HZ   4000000
`define PPFWB_SQ_MAX_INC  ((64'h100000000 * `PPFWB_SQ_MAX_HZ) / `PPFWB_CLK_HZ)
`define PPFWB_SQ_MSB      31

`endif

//--- src/ppfwb_pkg.sv
// types for the pin, pwm, square wave and wake block
`include "ppfwb_map.svh"

package ppfwb_pkg;

    typedef enum logic [1:0] {
        PPFWB_FN_GPIO,
        PPFWB_FN_PWM0,
        PPFWB_FN_PWM1,
        PPFWB_FN_SQ
    } ppfwb_fn_e;

    typedef enum logic [1:0] {
        PPFWB_WAKE_OFF,
        PPFWB_WAKE_LOW,
        PPFWB_WAKE_HIGH,
        PPFWB_WAKE_CHANGE
    } ppfwb_wake_e;

    typedef logic [`PPFWB_NUM_PINS-1:0] ppfwb_pins_t;
    typedef logic [`PPFWB_TIMER_W-1:0]  ppfwb_cnt_t;
    typedef logic [`PPFWB_NUM_WAKE-1:0] ppfwb_wk_t;

    typedef struct packed {
        ppfwb_pins_t                          dir;
        ppfwb_pins_t                          pull;
        ppfwb_pins_t                          level;
        ppfwb_fn_e [`PPFWB_NUM_PINS-1:0]      pin_function_select;
    } ppfwb_pin_cfg_s;

    typedef struct packed {
        ppfwb_cnt_t                           period;
        ppfwb_cnt_t [`PPFWB_NUM_PWM-1:0]      duty;
        ppfwb_cnt_t                           sq_inc;
    } ppfwb_pwm_cfg_s;

    typedef struct packed {
        logic [`PPFWB_DIV_W-1:0]              div;
        logic                                 tick;
        ppfwb_cnt_t                           cnt;
        logic [`PPFWB_NUM_PWM-1:0]            pwm;
        ppfwb_cnt_t                           acc;
        logic                                 sq;
        ppfwb_pins_t                          s1;
        ppfwb_pins_t                          s2;
        ppfwb_pins_t                          s3;
        ppfwb_pins_t                          pv;
        ppfwb_pins_t                          po;
        ppfwb_pins_t                          oe;
        ppfwb_wk_t                            w1;
        ppfwb_wk_t                            w2;
        ppfwb_wk_t                            w3;
        ppfwb_wk_t                            wv;
        ppfwb_wk_t                            wp;
        ppfwb_wk_t                            wake;
    } ppfwb_state_s;

endpackage

//--- verif/ppfwb_pins_model.sv
// external circuitry on the general pins: drives, pulls or floats each pin
`timescale 1ns/1ps

module ppfwb_pins_model (
    input  logic                   clk,
    input  ppfwb_pkg::ppfwb_pins_t pin_out,
    input  ppfwb_pkg::ppfwb_pins_t pin_oe,
    input  ppfwb_pkg::ppfwb_pins_t pin_pullup,
    input  ppfwb_pkg::ppfwb_pins_t ext_en,
    input  ppfwb_pkg::ppfwb_pins_t ext_level,
    output ppfwb_pkg::ppfwb_pins_t pin_in
);
    import ppfwb_pkg::*;

    // -------------------------------------------------------------
    // wire level
    // -------------------------------------------------------------
    // a floating pin wanders every cycle so a stale value never passes
    ppfwb_pins_t pat = 18'h2AAAA;

    always @(posedge clk)
    begin
        pat <= ~pat;
    end

    assign pin_in = (pin_oe & pin_out)
                  | (~pin_oe & ext_en & ext_level)
                  | (~pin_oe & ~ext_en & (pin_pullup | pat));
endmodule

//--- verif/tb.sv
// self-checking bench for the pin, pwm, square wave and wake block
`timescale 1ns/1ps
`include "ppfwb_map.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end

module tb;
    import ppfwb_pkg::*;
    logic           clk = 0;
    logic           resetn = 0;
    ppfwb_pin_cfg_s pin_cfg = '0;
    ppfwb_pwm_cfg_s pwm_cfg = '0;
    ppfwb_wake_e [`PPFWB_NUM_WAKE-1:0] wake_mode = {3{PPFWB_WAKE_OFF}};
    ppfwb_pins_t    pin_in, pin_out, pin_oe, pin_pullup, pin_value;
    ppfwb_pins_t    ext_en = '0;
    ppfwb_pins_t    ext_level = '0;
    ppfwb_wk_t      wake_pin = '1;
    ppfwb_wk_t      wake_event;
    logic           wake_any;
    int             err_count = 0;
    int             total_checks = 0;
    int             hi, ed, cnt;

    pin_pwm_square_wave_output_wake_block pin_pwm_square_wave_output_wake_block_i (.clk(clk), .resetn(resetn),
        .pin_cfg(pin_cfg), .pwm_cfg(pwm_cfg), .wake_mode(wake_mode), .pin_in(pin_in),
        .wake_pin(wake_pin), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .pin_value(pin_value), .wake_event(wake_event), .wake_any(wake_any));
    ppfwb_pins_model ppfwb_pins_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_level(ext_level), .pin_in(pin_in));

    initial
    begin
        forever #25 clk = ~clk;
    end

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    // high cycles and rising edges of one pin over a window
    task automatic measure(input int idx, input int n);
        logic prev;
        hi = 0;
        ed = 0;
        prev = pin_out[idx];
        repeat (n)
        begin
            step(1);
            if (pin_out[idx] === 1'b1) hi++;
            if (pin_out[idx] === 1'b1 && prev === 1'b0) ed++;
            prev = pin_out[idx];
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic test_gpio_out;
        pin_cfg = '0;
        pin_cfg.dir = 18'h2AAAA;
        pin_cfg.level = 18'h3C3C3;
        pin_cfg.pull = '1;
        step(2);
        `CHK(pin_oe, 18'h2AAAA)
        `CHK(pin_out & pin_cfg.dir, 18'h28282)
        `CHK(pin_pullup, 18'h15555)
        $display("test gpio_out done");
    endtask

    task automatic test_gpio_in;
        pin_cfg = '0;
        pin_cfg.pull = 18'h0FF00;
        ext_en = 18'h000FF;
        ext_level = 18'h000A5;
        step(6);
        `CHK(pin_value & 18'h0FFFF, 18'h0FFA5)
        `CHK(pin_pullup, 18'h0FF00)
        ext_level = 18'h0005A;
        step(6);
        `CHK(pin_value & 18'h000FF, 18'h0005A)
        ext_en = '0;
        $display("test gpio_in done");
    endtask

    // window of 400 clocks holds a whole number of pwm periods
    task automatic pwm_case(input int per, d0, d1, hi0, ed0, hi1);
        pwm_cfg.period = 32'(per);
        pwm_cfg.duty[0] = 32'(d0);
        pwm_cfg.duty[1] = 32'(d1);
        step(60);
        `CHK(pin_oe[5:4], 2'b11)
        measure(4, 400);
        `CHK(hi, hi0)
        `CHK(ed, ed0)
        measure(5, 400);
        `CHK(hi, hi1)
    endtask

    task automatic test_pwm;
        pin_cfg = '0;
        pin_cfg.pin_function_select[4] = PPFWB_FN_PWM0;
        pin_cfg.pin_function_select[5] = PPFWB_FN_PWM1;
        pin_cfg.pin_function_select[6] = PPFWB_FN_SQ;
        pwm_case(8, 3, 8, 150, 10, 400);
        pwm_case(2, 1, 0, 100, 20, 0);
        pwm_case(8, 0, 5, 0, 0, 250);
        $display("test pwm done");
    endtask

    task automatic test_square;
        pwm_cfg.sq_inc = 32'h08000000;
        step(40);
        measure(6, 320);
        `CHK(hi, 160)
        `CHK(ed, 10)
        pwm_cfg.sq_inc = '0;
        step(5);
        measure(6, 320);
        `CHK(ed, 0)
        pwm_cfg.sq_inc = 32'hFFFFFFFF;
        step(5);
        measure(6, 320);
        `CHK(ed >= 63 && ed <= 64, 1'b1)
        $display("test square done");
    endtask

    task automatic test_wake;
        for (int i = 0; i < 3; i++)
        begin
            wake_mode = {3{PPFWB_WAKE_OFF}};
            wake_pin = '1;
            step(6);
            `CHK(wake_any, 1'b0)
            wake_mode[i] = PPFWB_WAKE_LOW;
            wake_pin[i] = 1'b0;
            step(6);
            `CHK(wake_event, 3'(1 << i))
            wake_pin[i] = 1'b1;
            step(6);
            `CHK(wake_event, 3'b000)
            wake_mode[i] = PPFWB_WAKE_HIGH;
            step(2);
            `CHK(wake_any, 1'b1)
            wake_mode[i] = PPFWB_WAKE_CHANGE;
            step(2);
            wake_pin[i] = 1'b0;
            cnt = 0;
            repeat (10)
            begin
                step(1);
                if (wake_event[i] === 1'b1) cnt++;
            end
            `CHK(cnt, 1)
        end
        $display("test wake done");
    endtask

    initial
    begin
        #1000000;
        err_count++;
        results();
    end

    initial
    begin
        step(4);
        resetn = 1'b1;
        step(2);
        test_gpio_out();
        test_gpio_in();
        test_pwm();
        test_square();
        test_wake();
        results();
    end
endmodule
